// File: inc/acbd_defs.svh
// Constants for the vendor ATA command block decoder
// Operation
// - Flag 0: device select write happens before command register writes.
// - Flag 1: device select write happens after command register writes.
// - Readback-only: read selected taskfile registers, return zero for unselected ones.
// - Readback flag 0: execute command block normally with data phase.
// - Readback layout: altstatus, devhead, error, HOB=1 group, then HOB=0 group.
// - Byte four upper nibble is log2 of DRQ block size, legal 0..8.
// - Illegal block size: do not execute, report command failed.
// - Extended flag 1 accesses previous-content registers; 0 skips them.
// - Taskfile accesses follow select bitmap in ascending bit order.
`ifndef ACBD_DEFS_SVH
`define ACBD_DEFS_SVH
`define ACBD_OFF_CTRL 12'h000
`define ACBD_OFF_SEL 12'h004
`define ACBD_OFF_DEVH 12'h008
`define ACBD_OFF_STAT 12'h00C
`define ACBD_OFF_RB0 12'h010
`define ACBD_OFF_RB1 12'h014
`define ACBD_OFF_RB2 12'h018
`define ACBD_OFF_WD0 12'h020
`define ACBD_OFF_WD1 12'h024
`define ACBD_OFF_WD2 12'h028
`define ACBD_BIT_READBACK 0
`define ACBD_BIT_DEVAFTER 1
`define ACBD_BIT_EXT 8
`define ACBD_BIT_START 16
`define ACBD_BS_LSB 12
`define ACBD_BS_MAX 4'h8
`define ACBD_ST_BUSY 0
`define ACBD_ST_DONE 1
`define ACBD_ST_FAIL 2
`define ACBD_ST_DATA 3
`define ACBD_TF_ALT 4'h6
`define ACBD_TF_ERR 4'h1
`define ACBD_TF_SC 4'h2
`define ACBD_TF_DEVH 4'h6
`define ACBD_TF_CMD 4'h7
`define ACBD_TF_DCTL 4'hE
`define ACBD_HOB_SET 8'h80
`define ACBD_HOB_CLR 8'h00
`define ACBD_RB_BYTES 12
`endif

// File: inc/acbd_pkg.sv
// Types for the vendor ATA command block decoder
package acbd_pkg;
  typedef enum logic [7:0] {
    ACBD_IDLE = 8'h01,
    ACBD_CHECK = 8'h02,
    ACBD_DEVSEL = 8'h04,
    ACBD_HOBON = 8'h08,
    ACBD_ACCESS = 8'h10,
    ACBD_HOBOFF = 8'h20,
    ACBD_WAIT = 8'h40,
    ACBD_FINISH = 8'h80
  } acbd_state_t;
  typedef logic [7:0] acbd_byte_t;
endpackage : acbd_pkg

// File: inc/acbd_tf_if.sv
// Taskfile access carrier between sequencer and port
`timescale 1ns/1ps
`default_nettype none
interface acbd_tf_if;
  logic req;
  logic write;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport seq (output req, output write, output addr, output wdata, input rdata, input ack);
  modport port (input req, input write, input addr, input wdata, output rdata, output ack);
endinterface : acbd_tf_if
`default_nettype wire

// File: logic/acbd_decoder.sv
// Vendor ATA command block decoder with APB register slave
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "acbd_defs.svh"
module acbd_decoder (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tfStrobe,
  output logic tfWrite,
  output logic [3:0] tfAddr,
  output logic [7:0] tfDataOut,
  input wire logic [7:0] tfDataIn,
  input wire logic tfDone,
  output logic dataPhaseReq,
  input wire logic dataPhaseDone
);
  import acbd_pkg::*;
  acbd_tf_if tf ();
  acbd_tf_port u_port (.clock(clock), .rst_n(rst_n), .tf(tf), .tfStrobe(tfStrobe), .tfWrite(tfWrite),
    .tfAddr(tfAddr), .tfDataOut(tfDataOut), .tfDataIn(tfDataIn), .tfDone(tfDone));
  // ==========================================
  // Registers
  logic [31:0] ctrl, next_ctrl;
  acbd_byte_t sel, next_sel, devHead, next_devHead;
  acbd_byte_t wd [0:9];
  acbd_byte_t next_wd [0:9];
  acbd_byte_t rb [0:11];
  acbd_byte_t next_rb [0:11];
  logic stBusy, stDone, stFail, next_stBusy, next_stDone, next_stFail;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic dpMeta, dpSync;
  acbd_state_t state, next_state;
  logic [3:0] step, next_step;
  logic hobPass, next_hobPass;
  logic req, next_req, wr, next_wr;
  logic [3:0] addr, next_addr;
  acbd_byte_t wdat, next_wdat;
  logic next_dataPhaseReq;
  wire readback = ctrl[`ACBD_BIT_READBACK];
  wire devAfter = ctrl[`ACBD_BIT_DEVAFTER];
  wire extWrite = ctrl[`ACBD_BIT_EXT];
  wire [3:0] blockLog = ctrl[`ACBD_BS_LSB +: 4];
  wire apbAccess = psel && penable && !pready;
  wire startCmd = apbAccess && pwrite && paddr == `ACBD_OFF_CTRL && pwdata[`ACBD_BIT_START] && !stBusy;
  function automatic logic [31:0] packWord(input acbd_byte_t b0, b1, b2, b3);
    packWord = {b3, b2, b1, b0};
  endfunction : packWord
  // Taskfile address for select bit n: bit 0 maps to altstatus address 6, other bits pass unchanged
  function automatic logic [3:0] tfAddrOf(input logic [3:0] n);
    tfAddrOf = (n == 4'h0) ? `ACBD_TF_ALT : n;
  endfunction : tfAddrOf
  // ==========================================
  // APB slave
  always_comb begin
    next_ctrl = ctrl;
    next_sel = sel;
    next_devHead = devHead;
    for (int i = 0; i < 10; i++) next_wd[i] = wd[i];
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (apbAccess) begin
      next_pready = 1'b1;
      if (pwrite) begin
        if (paddr == `ACBD_OFF_CTRL) begin
          if (!stBusy) next_ctrl = {16'h0000, pwdata[15:0]};
        end else if (paddr == `ACBD_OFF_SEL) begin
          next_sel = pwdata[7:0];
        end else if (paddr == `ACBD_OFF_DEVH) begin
          next_devHead = pwdata[7:0];
        end else if (paddr == `ACBD_OFF_WD0) begin
          for (int i = 0; i < 4; i++) next_wd[i] = pwdata[8*i +: 8];
        end else if (paddr == `ACBD_OFF_WD1) begin
          for (int i = 0; i < 4; i++) next_wd[4+i] = pwdata[8*i +: 8];
        end else if (paddr == `ACBD_OFF_WD2) begin
          next_wd[8] = pwdata[7:0];
          next_wd[9] = pwdata[15:8];
        end else if (paddr != `ACBD_OFF_STAT) begin
          next_pslverr = 1'b1;
        end
      end else begin
        if (paddr == `ACBD_OFF_CTRL) next_prdata = ctrl;
        else if (paddr == `ACBD_OFF_SEL) next_prdata = {24'h000000, sel};
        else if (paddr == `ACBD_OFF_DEVH) next_prdata = {24'h000000, devHead};
        else if (paddr == `ACBD_OFF_STAT) next_prdata = {28'h0000000, dataPhaseReq, stFail, stDone, stBusy};
        else if (paddr == `ACBD_OFF_RB0) next_prdata = packWord(rb[0], rb[1], rb[2], rb[3]);
        else if (paddr == `ACBD_OFF_RB1) next_prdata = packWord(rb[4], rb[5], rb[6], rb[7]);
        else if (paddr == `ACBD_OFF_RB2) next_prdata = packWord(rb[8], rb[9], rb[10], rb[11]);
        else if (paddr == `ACBD_OFF_WD0) next_prdata = packWord(wd[0], wd[1], wd[2], wd[3]);
        else if (paddr == `ACBD_OFF_WD1) next_prdata = packWord(wd[4], wd[5], wd[6], wd[7]);
        else if (paddr == `ACBD_OFF_WD2) next_prdata = {16'h0000, wd[9], wd[8]};
        else begin
          next_prdata = 32'h00000000;
          next_pslverr = 1'b1;
        end
      end
    end
  end
  // ==========================================
  // Sequencer
  // Step walks select bits 0..7; hobPass=1 is the previous-content pass
  always_comb begin
    next_state = state;
    next_step = step;
    next_hobPass = hobPass;
    next_req = req;
    next_wr = wr;
    next_addr = addr;
    next_wdat = wdat;
    next_stBusy = stBusy;
    next_stDone = stDone;
    next_stFail = stFail;
    next_dataPhaseReq = dataPhaseReq;
    for (int i = 0; i < 12; i++) next_rb[i] = rb[i];
    if (tf.ack) next_req = 1'b0;
    case (state)
      ACBD_IDLE: begin
        if (startCmd) begin
          next_stBusy = 1'b1;
          next_stDone = 1'b0;
          next_stFail = 1'b0;
          next_state = ACBD_CHECK;
        end
      end
      ACBD_CHECK: begin
        next_step = 4'h0;
        next_hobPass = 1'b0;
        if (blockLog > `ACBD_BS_MAX) begin
          next_stFail = 1'b1;
          next_state = ACBD_FINISH;
        end else if (readback) begin
          for (int i = 0; i < `ACBD_RB_BYTES; i++) next_rb[i] = 8'h00;
          next_hobPass = extWrite;
          next_state = extWrite ? ACBD_HOBON : ACBD_ACCESS;
        end else if (!devAfter) begin
          next_state = ACBD_DEVSEL;
        end else begin
          next_hobPass = 1'b1;
          next_state = ACBD_ACCESS;
        end
      end
      ACBD_DEVSEL: begin
        if (!req && !tf.ack) begin
          next_req = 1'b1;
          next_wr = 1'b1;
          next_addr = `ACBD_TF_DEVH;
          next_wdat = devHead;
        end else if (tf.ack) begin
          next_hobPass = 1'b1;
          next_state = devAfter ? ACBD_WAIT : ACBD_ACCESS;
        end
      end
      ACBD_HOBON: begin
        if (!req && !tf.ack) begin
          next_req = 1'b1;
          next_wr = 1'b1;
          next_addr = `ACBD_TF_DCTL;
          next_wdat = `ACBD_HOB_SET;
        end else if (tf.ack) begin
          next_step = 4'h2;
          next_state = ACBD_ACCESS;
        end
      end
      ACBD_ACCESS: begin
        // Write pass: low bytes first in hobPass=1 (prev content), then current
        if (step[3] || (hobPass && readback && step > 4'h5)) begin
          next_step = 4'h0;
          if (hobPass && readback) begin
            next_state = ACBD_HOBOFF;
          end else if (hobPass) begin
            // Previous-content pass over, current pass still owed
            next_hobPass = 1'b0;
            next_step = 4'h1;
          end else if (devAfter && !readback) begin
            next_state = ACBD_DEVSEL;
          end else begin
            next_state = ACBD_WAIT;
          end
        end else if (!sel[step[2:0]] || (step == 4'h6 && !readback) ||
                     (!readback && step == 4'h0) ||
                     (readback && step == 4'h7)) begin
          next_step = step + 4'h1;
        end else if (!readback && hobPass && (step < 4'h2 || step > 4'h5 || !extWrite)) begin
          next_step = step + 4'h1;
        end else if (!req && !tf.ack) begin
          next_req = 1'b1;
          next_wr = !readback;
          next_addr = tfAddrOf(step);
          next_wdat = (step == 4'h1) ? wd[0] : (step == 4'h7) ? wd[9] :
                      hobPass ? wd[step[2:0] - 3'h1] : wd[{1'b0, step[2:0]} + 4'h3];
        end else if (tf.ack) begin
          if (readback) begin
            if (hobPass) next_rb[step[2:0] + 3'h1] = tf.rdata;
            else if (step == 4'h0) next_rb[0] = tf.rdata;
            else if (step == 4'h1) next_rb[2] = tf.rdata;
            else if (step == 4'h6) next_rb[1] = tf.rdata;
            else next_rb[{1'b0, step[2:0]} + 4'h5] = tf.rdata;
          end
          next_step = step + 4'h1;
          if (!readback && hobPass && step == 4'h5) begin
            next_hobPass = 1'b0;
            next_step = 4'h1;
          end
        end
      end
      ACBD_HOBOFF: begin
        if (!req && !tf.ack) begin
          next_req = 1'b1;
          next_wr = 1'b1;
          next_addr = `ACBD_TF_DCTL;
          next_wdat = `ACBD_HOB_CLR;
        end else if (tf.ack) begin
          next_hobPass = 1'b0;
          next_step = 4'h0;
          next_state = ACBD_ACCESS;
        end
      end
      ACBD_WAIT: begin
        if (readback) begin
          next_state = ACBD_FINISH;
        end else if (!dataPhaseReq) begin
          next_dataPhaseReq = 1'b1;
        end else if (dpSync) begin
          next_dataPhaseReq = 1'b0;
          next_state = ACBD_FINISH;
        end
      end
      ACBD_FINISH: begin
        next_stBusy = 1'b0;
        next_stDone = 1'b1;
        next_state = ACBD_IDLE;
      end
      default: next_state = ACBD_IDLE;
    endcase
  end
  assign tf.req = req;
  assign tf.write = wr;
  assign tf.addr = addr;
  assign tf.wdata = wdat;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl <= 32'h00000000;
      sel <= 8'h00;
      devHead <= 8'h00;
      for (int i = 0; i < 10; i++) wd[i] <= 8'h00;
      for (int i = 0; i < 12; i++) rb[i] <= 8'h00;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      stBusy <= 1'b0;
      stDone <= 1'b0;
      stFail <= 1'b0;
      state <= ACBD_IDLE;
      step <= 4'h0;
      hobPass <= 1'b0;
      req <= 1'b0;
      wr <= 1'b0;
      addr <= 4'h0;
      wdat <= 8'h00;
      dataPhaseReq <= 1'b0;
      dpMeta <= 1'b0;
      dpSync <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      sel <= next_sel;
      devHead <= next_devHead;
      for (int i = 0; i < 10; i++) wd[i] <= next_wd[i];
      for (int i = 0; i < 12; i++) rb[i] <= next_rb[i];
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      stBusy <= next_stBusy;
      stDone <= next_stDone;
      stFail <= next_stFail;
      state <= next_state;
      step <= next_step;
      hobPass <= next_hobPass;
      req <= next_req;
      wr <= next_wr;
      addr <= next_addr;
      wdat <= next_wdat;
      dataPhaseReq <= next_dataPhaseReq;
      dpMeta <= dataPhaseDone;
      dpSync <= dpMeta;
    end
  end
  // ==========================================
  // Checks
  AST_BADSIZE_FAILS: assert property (@(posedge clock) disable iff (!rst_n)
    state == ACBD_CHECK && blockLog > `ACBD_BS_MAX |=> state == ACBD_FINISH ##1 stFail) else $error("bad size not failed");
  AST_BADSIZE_NOACCESS: assert property (@(posedge clock) disable iff (!rst_n)
    state == ACBD_CHECK && blockLog > `ACBD_BS_MAX |=> !req [*2]) else $error("bad size accessed taskfile");
  AST_READBACK_NOWRITE: assert property (@(posedge clock) disable iff (!rst_n)
    req && readback && state == ACBD_ACCESS |-> !wr) else $error("readback wrote taskfile");
  AST_READBACK_NODATA: assert property (@(posedge clock) disable iff (!rst_n)
    readback |-> !dataPhaseReq) else $error("readback entered data phase");
  AST_DEV_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
    state == ACBD_CHECK && !readback && !devAfter && blockLog <= `ACBD_BS_MAX |=> state == ACBD_DEVSEL) else $error("devsel not first");
  AST_DEV_AFTER: assert property (@(posedge clock) disable iff (!rst_n)
    state == ACBD_DEVSEL && tf.ack && devAfter |=> state == ACBD_WAIT) else $error("devsel not last");
  AST_HOB_CLEARED: assert property (@(posedge clock) disable iff (!rst_n)
    state == ACBD_HOBOFF && req |-> addr == `ACBD_TF_DCTL && wdat == `ACBD_HOB_CLR) else $error("hob not cleared");
  AST_STEP_UP: assert property (@(posedge clock) disable iff (!rst_n)
    state == ACBD_ACCESS && $past(state) == ACBD_ACCESS && !$changed(hobPass) |-> step >= $past(step)) else $error("step went down");
  AST_NOEXT_SKIP: assert property (@(posedge clock) disable iff (!rst_n)
    req && !readback && !extWrite && hobPass && state == ACBD_ACCESS |-> 1'b0) else $error("prev content written");
endmodule : acbd_decoder
`default_nettype wire

// File: logic/acbd_tf_port.sv
// Taskfile pin port: one access per request, registered pins
`timescale 1ns/1ps
`default_nettype none
module acbd_tf_port (
  input wire logic clock,
  input wire logic rst_n,
  acbd_tf_if.port tf,
  output logic tfStrobe,
  output logic tfWrite,
  output logic [3:0] tfAddr,
  output logic [7:0] tfDataOut,
  input wire logic [7:0] tfDataIn,
  input wire logic tfDone
);
  logic busy, next_busy;
  logic doneMeta, doneSync, doneLast;
  logic [7:0] dinMeta, dinSync;
  logic next_strobe, next_write, next_ack;
  logic [3:0] next_addr;
  logic [7:0] next_dout, next_rdata;
  // ==========================================
  // Handshake
  always_comb begin
    next_busy = busy;
    next_strobe = tfStrobe;
    next_write = tfWrite;
    next_addr = tfAddr;
    next_dout = tfDataOut;
    next_ack = 1'b0;
    next_rdata = tf.rdata;
    if (!busy && tf.req && !tf.ack) begin
      next_busy = 1'b1;
      next_strobe = 1'b1;
      next_write = tf.write;
      next_addr = tf.addr;
      next_dout = tf.wdata;
    end else if (busy && doneSync && !doneLast) begin
      next_busy = 1'b0;
      next_strobe = 1'b0;
      next_ack = 1'b1;
      next_rdata = dinSync;
    end
  end
  // Data is resynchronised too; drive holds it stable while done is up
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy <= 1'b0;
      tfStrobe <= 1'b0;
      tfWrite <= 1'b0;
      tfAddr <= 4'h0;
      tfDataOut <= 8'h00;
      tf.ack <= 1'b0;
      tf.rdata <= 8'h00;
      doneMeta <= 1'b0;
      doneSync <= 1'b0;
      doneLast <= 1'b0;
      dinMeta <= 8'h00;
      dinSync <= 8'h00;
    end else begin
      busy <= next_busy;
      tfStrobe <= next_strobe;
      tfWrite <= next_write;
      tfAddr <= next_addr;
      tfDataOut <= next_dout;
      tf.ack <= next_ack;
      tf.rdata <= next_rdata;
      doneMeta <= tfDone;
      doneSync <= doneMeta;
      doneLast <= doneSync;
      dinMeta <= tfDataIn;
      dinSync <= dinMeta;
    end
  end
endmodule : acbd_tf_port
`default_nettype wire

// File: tb/acbd_ata_model.sv
// Behavioural taskfile device seen through the decoder pins
`timescale 1ns/1ps
`default_nettype none
module acbd_ata_model (
  input wire logic clock,
  input wire logic tfStrobe,
  input wire logic tfWrite,
  input wire logic [3:0] tfAddr,
  input wire logic [7:0] tfDataOut,
  output logic [7:0] tfDataIn,
  output logic tfDone
);
  logic [7:0] cur [16];
  logic [7:0] prev [16];
  logic hob;
  int cnt;
  int delay;
  logic [12:0] accLog [$];
  initial begin
    for (int i = 0; i < 16; i++) begin
      cur[i] = 8'h10 + 8'(i);
      prev[i] = 8'h20 + 8'(i);
    end
    hob = 1'b0;
    cnt = 0;
    delay = 3;
    tfDone = 1'b0;
    tfDataIn = 8'hA5;
  end
  // =====================================
  // Access handling
  // Answer held until strobe drops, then bus no longer shows old data
  always @(posedge clock) begin
    if (tfStrobe && !tfDone) begin
      if (cnt >= delay) begin
        cnt <= 0;
        tfDone <= 1'b1;
        accLog.push_back({tfWrite, tfAddr, tfWrite ? tfDataOut : 8'h00});
        if (tfWrite && tfAddr == 4'hE) begin
          hob <= tfDataOut[7];
        end else if (tfWrite) begin
          cur[tfAddr] <= tfDataOut;
        end else begin
          tfDataIn <= hob ? prev[tfAddr] : cur[tfAddr];
        end
      end else begin
        cnt <= cnt + 1;
      end
    end else if (!tfStrobe && tfDone) begin
      tfDone <= 1'b0;
      tfDataIn <= ~tfDataIn;
    end
  end
endmodule : acbd_ata_model
`default_nettype wire

// File: tb/ata_command_block_decoder_tb.sv
// Self-checking bench for the command block decoder
`timescale 1ns/1ps
`default_nettype none
`include "acbd_defs.svh"
module ata_command_block_decoder_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tfStrobe;
  logic tfWrite;
  logic [3:0] tfAddr;
  logic [7:0] tfDataOut;
  logic [7:0] tfDataIn;
  logic tfDone;
  logic dataPhaseReq;
  logic dataPhaseDone = 1'b0;
  logic sawData = 1'b0;
  logic [31:0] rv;
  logic ev;
  int num_errors = 0;
  int cmp_count = 0;
  always #2 clock = ~clock;
  acbd_decoder i_acbd_decoder (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tfStrobe(tfStrobe), .tfWrite(tfWrite), .tfAddr(tfAddr),
    .tfDataOut(tfDataOut), .tfDataIn(tfDataIn), .tfDone(tfDone),
    .dataPhaseReq(dataPhaseReq), .dataPhaseDone(dataPhaseDone));
  acbd_ata_model i_acbd_ata_model (.clock(clock), .tfStrobe(tfStrobe), .tfWrite(tfWrite),
    .tfAddr(tfAddr), .tfDataOut(tfDataOut), .tfDataIn(tfDataIn), .tfDone(tfDone));
  // Data phase acknowledged a few cycles late, like a slow host
  always @(posedge clock) begin
    if (dataPhaseReq === 1'b1) sawData <= 1'b1;
    dataPhaseDone <= dataPhaseReq && sawData;
  end
  // =====================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    ev = pslverr;
    if (n >= 50) chk(32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic chk_log(input logic [12:0] exp [$]);
    chk(32'(i_acbd_ata_model.accLog.size()), 32'(exp.size()));
    foreach (exp[i]) begin
      if (i < i_acbd_ata_model.accLog.size()) chk(32'(i_acbd_ata_model.accLog[i]), 32'(exp[i]));
    end
  endtask : chk_log
  task automatic run(input logic [7:0] sel, input logic [31:0] ctrl);
    int n;
    n = 0;
    i_acbd_ata_model.accLog.delete();
    sawData <= 1'b0;
    apb(1'b1, `ACBD_OFF_SEL, {24'h0, sel});
    apb(1'b1, `ACBD_OFF_CTRL, ctrl);
    do begin
      apb(1'b0, `ACBD_OFF_STAT, 32'h0);
      n++;
    end while (!(rv[`ACBD_ST_BUSY] === 1'b0 && (rv[`ACBD_ST_DONE] | rv[`ACBD_ST_FAIL]) === 1'b1) && n < 100);
    if (n >= 100) chk(rv, 32'h2);
  endtask : run
  task automatic rb(input logic [31:0] b0, input logic [31:0] b1, input logic [31:0] b2);
    apb(1'b0, `ACBD_OFF_RB0, 32'h0);
    chk(rv, b0);
    apb(1'b0, `ACBD_OFF_RB1, 32'h0);
    chk(rv, b1);
    apb(1'b0, `ACBD_OFF_RB2, 32'h0);
    chk(rv, b2);
  endtask : rb
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // =====================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    test_done;
  end
  // =====================================
  // Tests
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, `ACBD_OFF_STAT, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk({rv[31:1], ev}, 32'h1);
    $display("test reset_unmapped done");
    // Readback, extended, all selected; reserved bits zero
    run(8'hFF, 32'h0001_0101);
    chk_log('{13'h1E80, 13'h0200, 13'h0300, 13'h0400, 13'h0500, 13'h1E00,
      13'h0600, 13'h0100, 13'h0200, 13'h0300, 13'h0400, 13'h0500, 13'h0600});
    rb(32'h2211_1616, 32'h1225_2423, 32'h0015_1413);
    apb(1'b0, `ACBD_OFF_STAT, 32'h0);
    chk(rv & 32'hF, 32'h2);
    chk(32'(sawData), 32'h0);
    $display("test readback_ext done");
    // Slow device, largest legal block size, sparse map
    i_acbd_ata_model.delay = 12;
    run(8'h05, 32'h0001_8001);
    chk_log('{13'h0600, 13'h0200});
    rb(32'h0000_0016, 32'h1200_0000, 32'h0);
    i_acbd_ata_model.delay = 3;
    $display("test readback_sparse done");
    // Illegal block sizes
    for (int b = 9; b < 16; b += 6) begin
      run(8'hFF, {16'h0001, 4'(b), 12'h001});
      chk({29'h0, rv[2:0]} & 32'h5, 32'h4);
      chk_log('{});
    end
    $display("test bad_block_size done");
    // Normal command, selection first, extended
    apb(1'b1, `ACBD_OFF_DEVH, 32'h0000_00E0);
    apb(1'b1, `ACBD_OFF_WD0, 32'h4433_2211);
    apb(1'b1, `ACBD_OFF_WD1, 32'h8877_6655);
    apb(1'b1, `ACBD_OFF_WD2, 32'h0000_AA99);
    run(8'hBE, 32'h0001_0100);
    chk_log('{13'h16E0, 13'h1222, 13'h1333, 13'h1444, 13'h1555, 13'h1111,
      13'h1266, 13'h1377, 13'h1488, 13'h1599, 13'h17AA});
    chk(32'(sawData), 32'h1);
    chk(rv & 32'hF, 32'h2);
    $display("test normal_before done");
    // Normal command, selection after, not extended
    run(8'h82, 32'h0001_0002);
    chk_log('{13'h1111, 13'h17AA, 13'h16E0});
    chk(32'(sawData), 32'h1);
    $display("test normal_after done");
    test_done;
  end
endmodule : ata_command_block_decoder_tb
`default_nettype wire
